// *** rtl/sfe_exc_unit.sv ***
// Vector floating-point exception detection, flagging and reporting
//
// Chosen here: strobed register access and the address map.
`timescale 1ns/100ps
`default_nettype none

module sfe_exc_unit
    import sfe_pkg::*;
(
    input  wire logic                  clock,
    input  wire logic                  resetn,
    input  wire logic [7:0]            reg_addr,
    input  wire logic [31:0]           reg_wdata,
    input  wire logic                  reg_write,
    input  wire logic                  reg_read,
    output logic      [31:0]           reg_rdata,
    input  wire logic                  ex_valid,
    input  wire logic [3:0]            ex_op,
    input  wire logic                  ex_packed,
    input  wire logic [2:0]            ex_pred,
    input  wire logic                  ex_ftz,
    input  wire logic [127:0]          ex_src1,
    input  wire logic [127:0]          ex_src2,
    input  wire logic [127:0]          ex_dest_old,
    input  wire logic [127:0]          ex_result,
    input  wire logic [2:0]            ex_cond,
    input  wire logic [19:0]           ex_lane_flags,
    output logic                       done,
    output logic                       wb_en,
    output logic      [127:0]          wb_data,
    output logic                       cond_valid,
    output logic      [2:0]            cond_flags,
    output logic                       vec_fp_fault,
    output logic                       invalid_opcode_fault
);

    sfe_state_t       st;
    sfe_state_t       next_st;

    logic [3:0]       lane_inv;
    logic [3:0]       lane_ovr;
    logic [31:0]      lane_val [SFE_LANES];
    logic [3:0]       lane_act;
    logic [5:0]       raised;
    logic [127:0]     merged;
    logic [63:0]      s2d_quiet;
    logic             scalar_only;
    logic             ftz_unused;

    // Returns {invalid, override, masked value} for one single-precision lane
    function automatic logic [33:0] sfe_lane_eval(
        input logic [3:0]  op,
        input logic [2:0]  pred,
        input logic [31:0] a,
        input logic [31:0] b
    );
        logic        a_nan;
        logic        b_nan;
        logic        a_snan;
        logic        b_snan;
        logic        a_inf;
        logic        b_inf;
        logic        a_zero;
        logic        b_zero;
        logic        inv;
        logic        ovr;
        logic [31:0] val;
        logic [31:0] quiet;
        a_nan  = (a[30:23] == SFE_EXP_MAX) && (a[22:0] != 23'h0);
        b_nan  = (b[30:23] == SFE_EXP_MAX) && (b[22:0] != 23'h0);
        a_snan = a_nan && !a[SFE_QUIET_BIT];
        b_snan = b_nan && !b[SFE_QUIET_BIT];
        a_inf  = (a[30:23] == SFE_EXP_MAX) && (a[22:0] == 23'h0);
        b_inf  = (b[30:23] == SFE_EXP_MAX) && (b[22:0] == 23'h0);
        a_zero = (a[30:0] == 31'h0);
        b_zero = (b[30:0] == 31'h0);
        inv    = 1'b0;
        ovr    = 1'b0;
        val    = SFE_QNAN_INDEF;
        quiet  = a_snan ? (a | (32'h1 << SFE_QUIET_BIT)) : (b | (32'h1 << SFE_QUIET_BIT));
        case (op)
            SFE_OP_ADD, SFE_OP_SUB, SFE_OP_MUL, SFE_OP_DIV:
            begin
                if (a_snan || b_snan)
                begin
                    inv = 1'b1;
                    val = quiet;
                end
                else if (!a_nan && !b_nan)
                begin
                    case (op)
                        SFE_OP_ADD: inv = a_inf && b_inf && (a[31] != b[31]);
                        SFE_OP_SUB: inv = a_inf && b_inf && (a[31] == b[31]);
                        SFE_OP_MUL: inv = (a_inf && b_zero) || (a_zero && b_inf);
                        default:    inv = (a_zero && b_zero) || (a_inf && b_inf);
                    endcase
                    val = SFE_QNAN_INDEF;
                end
                ovr = inv;
            end
            SFE_OP_SQRT:
            begin
                if (b_snan)
                begin
                    inv = 1'b1;
                    val = b | (32'h1 << SFE_QUIET_BIT);
                end
                else if (!b_nan && b[31] && !b_zero)
                begin
                    inv = 1'b1;
                    val = SFE_QNAN_INDEF;
                end
                ovr = inv;
            end
            SFE_OP_MAX, SFE_OP_MIN:
            begin
                inv = a_nan || b_nan;
                ovr = inv;
                val = b;
            end
            SFE_OP_CMP:
            begin
                // quiet NaN invalid only on ordering predicates
                inv = a_snan || b_snan ||
                      ((a_nan || b_nan) && (pred == SFE_PRED_LT || pred == SFE_PRED_LE ||
                                            pred == SFE_PRED_NLT || pred == SFE_PRED_NLE));
                ovr = a_nan || b_nan;
                val = (pred == SFE_PRED_NEQ || pred == SFE_PRED_UNO ||
                       pred == SFE_PRED_NLT || pred == SFE_PRED_NLE) ? SFE_ALL_ONES : SFE_ALL_ZEROS;
            end
            SFE_OP_COMI:
            begin
                // ordered compare raises invalid on any NaN
                inv = a_nan || b_nan;
                ovr = inv;
                val = SFE_ALL_ZEROS;
            end
            SFE_OP_S2D:
            begin
                // signaling source detected here, widened outside
                inv = b_snan;
                ovr = inv;
                val = SFE_ALL_ZEROS;
            end
            SFE_OP_F2I:
            begin
                inv = b_nan || b_inf ||
                      ((b[30:23] >= SFE_F2I_EXP_LIMIT) && (b != SFE_INT_MIN_FLOAT));
                ovr = inv;
                val = SFE_INT_INDEF;
            end
            default:
            begin
                inv = 1'b0;
                ovr = 1'b0;
                val = SFE_ALL_ZEROS;
            end
        endcase
        return {inv, ovr, val};
    endfunction

    for (genvar i = 0; i < SFE_LANES; i++)
    begin : g_lane
        assign {lane_inv[i], lane_ovr[i], lane_val[i]} =
            sfe_lane_eval(ex_op, ex_pred, ex_src1[i*SFE_LANE_W +: SFE_LANE_W], ex_src2[i*SFE_LANE_W +: SFE_LANE_W]);
        assign merged[i*SFE_LANE_W +: SFE_LANE_W] =
            !lane_act[i] ? ex_dest_old[i*SFE_LANE_W +: SFE_LANE_W] :
            lane_ovr[i]  ? lane_val[i] : ex_result[i*SFE_LANE_W +: SFE_LANE_W];
    end

    // flush-to-zero has no say in invalid detection
    assign ftz_unused  = ex_ftz;
    assign scalar_only = !ex_packed || (ex_op == SFE_OP_COMI) || (ex_op == SFE_OP_S2D);
    assign lane_act    = scalar_only ? 4'h1 : 4'hf;
    // quiet double built from the single source
    assign s2d_quiet   = {ex_src2[31], SFE_DEXP_MAX, 1'b1, ex_src2[21:0], 29'h0};

    always_comb
    begin
        next_st                      = st;
        next_st.rdata                = 32'h0;
        next_st.done                 = 1'b0;
        next_st.wb_en                = 1'b0;
        next_st.cond_valid           = 1'b0;
        next_st.vec_fp_fault         = 1'b0;
        next_st.invalid_opcode_fault = 1'b0;
        raised                       = 6'h0;

        // store/save view of masks and flags
        if (reg_read)
        begin
            case (reg_addr)
                SFE_REG_CTRL_STAT: next_st.rdata = {16'h0, st.csr};
                SFE_REG_SYS_CTRL:  next_st.rdata = 32'(st.os_support) << SFE_SYS_OS_BIT;
                default:           next_st.rdata = 32'h0;
            endcase
        end

        if (reg_write)
        begin
            case (reg_addr)
                SFE_REG_CTRL_STAT: next_st.csr = reg_wdata[SFE_CSR_W-1:0];
                SFE_REG_SYS_CTRL:  next_st.os_support = reg_wdata[SFE_SYS_OS_BIT];
                default:           next_st.csr = next_st.csr;
            endcase
        end

        if (ex_valid)
        begin
            // OR of each class across active elements
            raised[SFE_INVALID_BIT] = |(lane_inv & lane_act);
            for (int k = 0; k < SFE_SIDE_CLASSES; k++)
            begin
                for (int l = 0; l < SFE_LANES; l++)
                begin
                    raised[k+1] = raised[k+1] | (ex_lane_flags[l*SFE_SIDE_CLASSES + k] & lane_act[l]);
                end
            end
            // sticky set, wins over a same-cycle rewrite
            next_st.csr[SFE_FLAG_LSB +: SFE_CLASSES] = next_st.csr[SFE_FLAG_LSB +: SFE_CLASSES] | raised;
            next_st.done = 1'b1;
            // a class traps only where its mask bit is clear
            if (|(raised & ~st.csr[SFE_MASK_LSB +: SFE_CLASSES]))
            begin
                // vector fault when OS supports it
                next_st.vec_fp_fault = st.os_support;
                next_st.invalid_opcode_fault = !st.os_support;
                next_st.wb_en = 1'b0;
            end
            else if (ex_op == SFE_OP_COMI)
            begin
                next_st.cond_valid = 1'b1;
                next_st.cond_flags = lane_ovr[0] ? SFE_COND_UNORD : ex_cond;
            end
            else
            begin
                next_st.wb_en = 1'b1;
                if (ex_op == SFE_OP_S2D)
                begin
                    next_st.wb_data = {ex_dest_old[127:64], lane_ovr[0] ? s2d_quiet : ex_result[63:0]};
                end
                else
                begin
                    next_st.wb_data = merged;
                end
            end
        end
    end

    always_ff @(posedge clock or negedge resetn)
    begin
        if (!resetn)
        begin
            st            <= '0;
            st.csr        <= SFE_CSR_RESET;
        end
        else
        begin
            st            <= next_st;
        end
    end

    assign reg_rdata            = st.rdata;
    assign done                 = st.done;
    assign wb_en                = st.wb_en;
    assign wb_data              = st.wb_data;
    assign cond_valid           = st.cond_valid;
    assign cond_flags           = st.cond_flags;
    assign vec_fp_fault         = st.vec_fp_fault;
    assign invalid_opcode_fault = st.invalid_opcode_fault;

endmodule // sfe_exc_unit

`default_nettype wire

// *** rtl/sfe_pkg.sv ***
// Constants and types for the vector floating-point exception unit
package sfe_pkg;

    // Lane geometry: four single-precision lanes in a 128-bit operand
    localparam int          SFE_LANES        = 4;
    localparam int          SFE_LANE_W       = 32;
    localparam int          SFE_VEC_W        = 128;
    localparam int          SFE_CLASSES      = 6;
    localparam int          SFE_SIDE_CLASSES = 5;

    // Register port
    localparam int          SFE_ADDR_W        = 8;
    localparam logic [7:0]  SFE_REG_CTRL_STAT = 8'h00;
    localparam logic [7:0]  SFE_REG_SYS_CTRL  = 8'h04;

    // Control/status layout
    localparam int          SFE_CSR_W          = 16;
    localparam int          SFE_INVALID_BIT    = 0;
    localparam int          SFE_DENORMAL_BIT   = 1;
    localparam int          SFE_DIV_ZERO_BIT   = 2;
    localparam int          SFE_OVERFLOW_BIT   = 3;
    localparam int          SFE_UNDERFLOW_BIT  = 4;
    localparam int          SFE_INEXACT_BIT    = 5;
    localparam int          SFE_FLAG_LSB       = 0;
    localparam int          SFE_MASK_LSB       = 7;
    localparam logic [15:0] SFE_CSR_RESET      = 16'h1f80;

    // System control register: OS support for the vector fault
    localparam int          SFE_SYS_OS_BIT     = 10;

    // Operation codes presented with a completing instruction
    localparam logic [3:0]  SFE_OP_ADD  = 4'h0;
    localparam logic [3:0]  SFE_OP_SUB  = 4'h1;
    localparam logic [3:0]  SFE_OP_MUL  = 4'h2;
    localparam logic [3:0]  SFE_OP_DIV  = 4'h3;
    localparam logic [3:0]  SFE_OP_SQRT = 4'h4;
    localparam logic [3:0]  SFE_OP_MAX  = 4'h5;
    localparam logic [3:0]  SFE_OP_MIN  = 4'h6;
    localparam logic [3:0]  SFE_OP_CMP  = 4'h7;
    localparam logic [3:0]  SFE_OP_COMI = 4'h8;
    localparam logic [3:0]  SFE_OP_S2D  = 4'h9;
    localparam logic [3:0]  SFE_OP_F2I  = 4'ha;

    // Compare predicates
    localparam logic [2:0]  SFE_PRED_LT  = 3'h1;
    localparam logic [2:0]  SFE_PRED_LE  = 3'h2;
    localparam logic [2:0]  SFE_PRED_UNO = 3'h3;
    localparam logic [2:0]  SFE_PRED_NEQ = 3'h4;
    localparam logic [2:0]  SFE_PRED_NLT = 3'h5;
    localparam logic [2:0]  SFE_PRED_NLE = 3'h6;

    // Single-precision and integer encodings, the double exponent and the unordered condition code
    localparam logic [7:0]  SFE_EXP_MAX       = 8'hff;
    localparam int          SFE_QUIET_BIT     = 22;
    localparam logic [31:0] SFE_QNAN_INDEF    = 32'hffc0_0000;
    localparam logic [31:0] SFE_INT_INDEF     = 32'h8000_0000;
    localparam logic [31:0] SFE_INT_MIN_FLOAT = 32'hcf00_0000;
    localparam logic [7:0]  SFE_F2I_EXP_LIMIT = 8'h9e;
    localparam logic [31:0] SFE_ALL_ONES      = 32'hffff_ffff;
    localparam logic [31:0] SFE_ALL_ZEROS     = 32'h0000_0000;
    localparam logic [10:0] SFE_DEXP_MAX      = 11'h7ff;
    localparam logic [2:0]  SFE_COND_UNORD    = 3'h7;

    typedef struct packed {
        logic [15:0]  csr;
        logic         os_support;
        logic [31:0]  rdata;
        logic         done;
        logic         wb_en;
        logic [127:0] wb_data;
        logic         cond_valid;
        logic [2:0]   cond_flags;
        logic         vec_fp_fault;
        logic         invalid_opcode_fault;
    } sfe_state_t;

endpackage

// *** dv/sfe_exc_monitor.sv ***
// Port-level assertions for the exception unit
`timescale 1ns/100ps
`default_nettype none
module sfe_exc_monitor
    import sfe_pkg::*;
(
    input wire logic         clock,
    input wire logic         resetn,
    input wire logic         reg_read,
    input wire logic [31:0]  reg_rdata,
    input wire logic         ex_valid,
    input wire logic [3:0]   ex_op,
    input wire logic [127:0] ex_src2,
    input wire logic         done,
    input wire logic         wb_en,
    input wire logic [127:0] wb_data,
    input wire logic         cond_valid,
    input wire logic         vec_fp_fault,
    input wire logic         invalid_opcode_fault
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!resetn);

    a_done_follows_valid: assert property (ex_valid |=> done) else $error("done missing");
    a_no_stray_done: assert property (!ex_valid |=> !done) else $error("done without instruction");
    a_fault_one_kind: assert property (!(vec_fp_fault && invalid_opcode_fault)) else $error("two faults");
    a_fault_no_write: assert property ((vec_fp_fault || invalid_opcode_fault) |-> done && !wb_en)
        else $error("fault with write");
    a_wb_data_holds: assert property (!wb_en |-> $stable(wb_data)) else $error("wb_data moved");
    a_read_data_brief: assert property (!reg_read |=> reg_rdata == 32'h0) else $error("stray rdata");
    a_comi_no_write: assert property (ex_valid && ex_op == SFE_OP_COMI |=> !wb_en) else $error("compare wrote");
    a_cond_from_comi: assert property (cond_valid |-> done && $past(ex_op) == SFE_OP_COMI)
        else $error("cond_valid without compare");
    a_sqrt_negative: assert property (ex_valid && ex_op == SFE_OP_SQRT && ex_src2[31]
        && ex_src2[30:23] != SFE_EXP_MAX && ex_src2[30:0] != 31'h0 ##1 wb_en |-> wb_data[31:0] == SFE_QNAN_INDEF)
        else $error("sqrt value");

    c_vec_fault: cover property (vec_fp_fault);
    c_opcode_fault: cover property (invalid_opcode_fault);
    c_cond: cover property (cond_valid);
    c_masked_write: cover property (wb_en);
endmodule // sfe_exc_monitor

bind sfe_exc_unit sfe_exc_monitor u_mon (.clock, .resetn, .reg_read, .reg_rdata, .ex_valid, .ex_op, .ex_src2,
    .done, .wb_en, .wb_data, .cond_valid, .vec_fp_fault, .invalid_opcode_fault);
`default_nettype wire

// *** dv/tb.sv ***
// Self-checking bench for the exception unit
`timescale 1ns/100ps
`default_nettype none
module tb
    import sfe_pkg::*;
;
    typedef struct packed {logic [3:0] op; logic [31:0] a, b, r; logic d, f;} sfe_case_t;
    logic         clock, resetn, reg_write, reg_read, ex_valid, ex_packed, ex_ftz;
    logic         done, wb_en, cond_valid, vec_fp_fault, invalid_opcode_fault;
    logic [7:0]   reg_addr;
    logic [31:0]  reg_wdata, reg_rdata;
    logic [3:0]   ex_op;
    logic [2:0]   ex_pred, ex_cond, cond_flags;
    logic [19:0]  ex_lane_flags;
    logic [127:0] ex_src1, ex_src2, ex_dest_old, ex_result, wb_data, rr;
    logic [15:0]  seed;
    int           failures, checked, cyc;
    sfe_case_t    tc [13];

    sfe_exc_unit u_dut (.clock, .resetn, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata,
        .ex_valid, .ex_op, .ex_packed, .ex_pred, .ex_ftz, .ex_src1, .ex_src2, .ex_dest_old, .ex_result,
        .ex_cond, .ex_lane_flags, .done, .wb_en, .wb_data, .cond_valid, .cond_flags, .vec_fp_fault,
        .invalid_opcode_fault);

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Flag classes sit one above the invalid flag, in lane-flag order
    function automatic logic [15:0] lane_or(input logic [19:0] lf);
        logic [4:0] o;
        o = lf[4:0] | lf[9:5] | lf[14:10] | lf[19:15];
        return SFE_CSR_RESET | {o, 1'b0};
    endfunction

    task automatic print_verdict();
        if (failures == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
        checked++;
        if (g !== e)
        begin
            failures++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        @(negedge clock);
        chk("reg_rdata", e, reg_rdata);
    endtask

    // Flush-to-zero is random on purpose: invalid handling must not depend on it
    task automatic ex(input logic [3:0] op, input logic pk, input logic [2:0] pr,
                      input logic [127:0] s1, input logic [127:0] s2, input logic [19:0] lf);
        @(posedge clock);
        seed = lfsr(seed);
        rr = {4{seed, ~seed}};
        {ex_op, ex_packed, ex_pred, ex_src1, ex_src2, ex_lane_flags} <= {op, pk, pr, s1, s2, lf};
        {ex_result, ex_dest_old, ex_ftz, ex_cond} <= {rr, ~rr, seed[0], seed[3:1]};
        ex_valid <= 1'b1;
        @(posedge clock);
        ex_valid <= 1'b0;
        @(negedge clock);
        chk("done", 1'b1, done);
    endtask

    initial
    begin
        clock = 1'b0;
        forever #25 clock = ~clock;
    end

    always @(posedge clock)
    begin
        cyc <= cyc + 1;
        if (cyc == 2000)
        begin
            failures++;
            print_verdict();
        end
    end

    initial
    begin
        {resetn, reg_write, reg_read, ex_valid, ex_packed, ex_ftz, reg_addr, reg_wdata} = '0;
        {ex_op, ex_pred, ex_cond, ex_lane_flags, ex_src1, ex_src2, ex_dest_old, ex_result} = '0;
        failures = 0;
        checked = 0;
        cyc = 0;
        seed = 16'h6cc4;
        tc[0] = '{SFE_OP_ADD, 32'h7f800001, 32'h0, 32'h7fc00001, 1'b0, 1'b1};
        tc[1] = '{SFE_OP_SQRT, 32'h0, 32'h7fa00000, 32'h7fe00000, 1'b0, 1'b1};
        tc[2] = '{SFE_OP_SQRT, 32'h0, 32'hbf800000, SFE_QNAN_INDEF, 1'b0, 1'b1};
        tc[3] = '{SFE_OP_MAX, 32'h7fc00000, 32'h3f800000, 32'h3f800000, 1'b0, 1'b1};
        tc[4] = '{SFE_OP_MIN, 32'h3f800000, 32'hff800001, 32'hff800001, 1'b0, 1'b1};
        tc[5] = '{SFE_OP_SUB, 32'h7f800000, 32'h7f800000, SFE_QNAN_INDEF, 1'b0, 1'b1};
        tc[6] = '{SFE_OP_MUL, 32'h7f800000, 32'h0, SFE_QNAN_INDEF, 1'b0, 1'b1};
        tc[7] = '{SFE_OP_DIV, 32'h0, 32'h0, SFE_QNAN_INDEF, 1'b0, 1'b1};
        tc[8] = '{SFE_OP_F2I, 32'h0, 32'h7f800000, SFE_INT_INDEF, 1'b0, 1'b1};
        tc[9] = '{SFE_OP_ADD, 32'h7fc00000, 32'h0, 32'h0, 1'b1, 1'b0};
        tc[10] = '{SFE_OP_ADD, 32'h7f800000, 32'hff800000, SFE_QNAN_INDEF, 1'b0, 1'b1};
        tc[11] = '{SFE_OP_F2I, 32'h0, 32'h4f000000, SFE_INT_INDEF, 1'b0, 1'b1};
        tc[12] = '{SFE_OP_F2I, 32'h0, SFE_INT_MIN_FLOAT, 32'h0, 1'b1, 1'b0};
        repeat (5) @(posedge clock);
        resetn <= 1'b1;
        wr(8'h08, 32'hffff_ffff);
        rd(8'h08, 32'h0);
        rd(SFE_REG_CTRL_STAT, SFE_CSR_RESET);
        ex(SFE_OP_ADD, 1'b1, 3'h0, {32'h0, 32'h7f800000, 64'h0}, {32'h0, 32'hff800000, 64'h0}, 20'h0);
        chk("wb_data", {rr[127:96], SFE_QNAN_INDEF, rr[63:0]}, wb_data);
        chk("wb_en", 1'b1, wb_en);
        ex(SFE_OP_ADD, 1'b1, 3'h0, '0, '0, 20'h0);
        rd(SFE_REG_CTRL_STAT, SFE_CSR_RESET | 16'h1);
        repeat (6)
        begin
            wr(SFE_REG_CTRL_STAT, SFE_CSR_RESET);
            seed = lfsr(seed);
            ex(SFE_OP_ADD, 1'b1, 3'h0, '0, '0, {seed[3:0], seed});
            rd(SFE_REG_CTRL_STAT, lane_or(ex_lane_flags));
        end
        foreach (tc[i])
        begin
            wr(SFE_REG_CTRL_STAT, SFE_CSR_RESET);
            ex(tc[i].op, 1'b0, 3'h0, tc[i].a, tc[i].b, 20'h0);
            chk("wb_data", {~rr[127:32], tc[i].d ? rr[31:0] : tc[i].r}, wb_data);
            rd(SFE_REG_CTRL_STAT, SFE_CSR_RESET | tc[i].f);
        end
        for (int p = 0; p < 8; p++)
        begin
            ex(SFE_OP_CMP, 1'b0, p[2:0], 32'h7f800001, 32'h0, 20'h0);
            chk("cmp", {~rr[127:32], (p inside {3, 4, 5, 6}) ? SFE_ALL_ONES : SFE_ALL_ZEROS}, wb_data);
        end
        for (int q = 0; q < 2; q++)
        begin
            wr(SFE_REG_CTRL_STAT, SFE_CSR_RESET);
            ex(SFE_OP_CMP, 1'b0, q[0] ? SFE_PRED_LT : 3'h0, 32'h7fc00000, 32'h0, 20'h0);
            rd(SFE_REG_CTRL_STAT, SFE_CSR_RESET | q[0]);
        end
        wr(SFE_REG_CTRL_STAT, SFE_CSR_RESET);
        ex(SFE_OP_COMI, 1'b0, 3'h0, 32'h7fc00000, 32'h3f800000, 20'h0);
        chk("cond_valid", 1'b1, cond_valid);
        chk("cond_flags", SFE_COND_UNORD, cond_flags);
        rd(SFE_REG_CTRL_STAT, SFE_CSR_RESET | 16'h1);
        ex(SFE_OP_COMI, 1'b0, 3'h0, 32'h3f800000, 32'h40000000, 20'h0);
        chk("cond_valid", 1'b1, cond_valid);
        chk("cond_flags", ex_cond, cond_flags);
        ex(SFE_OP_S2D, 1'b0, 3'h0, 32'h0, 32'h7f800001, 20'h0);
        chk("s2d", {~rr[127:64], 64'h7ff8_0000_2000_0000}, wb_data);
        wr(SFE_REG_CTRL_STAT, 32'hffff_1f00);
        rd(SFE_REG_CTRL_STAT, 32'h0000_1f00);
        for (int o = 1; o >= 0; o--)
        begin
            wr(SFE_REG_SYS_CTRL, o[0] ? 32'hffff_ffff : 32'hffff_fbff);
            rd(SFE_REG_SYS_CTRL, o << SFE_SYS_OS_BIT);
            ex(SFE_OP_MUL, 1'b0, 3'h0, 32'h7f800000, 32'h0, 20'h0);
            chk("vec_fp_fault", o[0], vec_fp_fault);
            chk("invalid_opcode_fault", !o[0], invalid_opcode_fault);
            chk("wb_en", 1'b0, wb_en);
        end
        rd(SFE_REG_CTRL_STAT, 32'h0000_1f01);
        print_verdict();
    end
endmodule // tb
`default_nettype wire
